// file: pid_reg_consts.svh
// register map, reset values, legal ranges, scale factors and timing for the process regulator
`ifndef PID_REG_CONSTS_SVH
`define PID_REG_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RG_CTRL 8'h00
`define RG_SP1 8'h04
`define RG_SP2 8'h08
`define RG_RREF 8'h0C
`define RG_BFB1 8'h10
`define RG_BFB2 8'h14
`define RG_KP 8'h18
`define RG_TI 8'h1C
`define RG_TD 8'h20
`define RG_DGAIN 8'h24
`define RG_TAU 8'h28
`define RG_HFREQ 8'h2C
`define RG_FMIN 8'h30
`define RG_FMAX 8'h34
`define RG_STATUS 8'h38
`define RG_FBF 8'h3C
`define RG_DEMAND 8'h40

// ----------------------------------------------------------------
// reset values and legal ranges
// ----------------------------------------------------------------
`define CTRL_RST 8'h21
`define KP_RST 16'h0029
`define KP_MAX 32'h0000A000
`define TI_MAX 32'h000F41DC
`define TD_MAX 32'h000003E8
`define DG_MIN 32'h00000032
`define DG_MAX 32'h000001F4
`define TAU_MIN 32'h00000001
`define TAU_MAX 32'h000003E8
`define FMAX_RST 16'h01F4
`define KP_FRAC 12
`define DER_SCALE 20'h0000A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAMPLE_US 10000
`define CLK_NS 5
`define SAMPLE_CYCLES_DEF (`SAMPLE_US * 1000 / `CLK_NS)

`endif

// file: pid_reg_pkg.sv
// types shared by the process regulator files
package pid_reg_pkg;
   typedef enum logic [3:0] {
      CMB_MIN, CMB_MAX, CMB_SUM, CMB_DIFF, CMB_AVG,
      CMB_ZONE_MIN, CMB_ZONE_MAX, CMB_FB1, CMB_FB2
   } combine_e;
   typedef enum logic [2:0] {ST_WAIT, ST_FILT, ST_ERR, ST_INT, ST_DER, ST_OUT} calc_state_e;
   typedef enum logic [1:0] {PH_STOP, PH_RAMP, PH_REG} run_phase_e;
   typedef struct packed {
      logic start;
      logic closed_loop;
      logic integrator_clamp_enable;
      logic loop_direction_select;
      combine_e feedback_combine_select;
   } ctrl_s;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      logic cur_lim;
      logic volt_lim;
   } limit_s;
endpackage

// file: pid_divider.sv
// sequential signed-by-unsigned divider, quotient truncated toward zero
`timescale 1ns/1ps
module pid_divider #(
   parameter int DW = 32,
   parameter int VW = 20
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic signed [DW-1:0] num_i,
   input wire logic [VW-1:0] den_i,
   output logic done_o,
   output logic signed [DW-1:0] quo_o
);
   localparam int CW = $clog2(DW + 1);
   logic [DW-1:0] q_reg;
   logic [VW:0] acc_reg;
   logic [VW-1:0] den_reg;
   logic [CW-1:0] cnt_reg;
   logic neg_reg;
   logic busy_reg;
   logic [VW:0] shifted;
   logic fits;

   assign shifted = {acc_reg[VW-1:0], q_reg[DW-1]};
   assign fits = shifted >= {1'b0, den_reg};

   // one quotient bit per clock; caller never passes a zero divisor
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_reg <= '0;
         acc_reg <= '0;
         den_reg <= '0;
         cnt_reg <= '0;
         neg_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_o <= 1'b0;
         quo_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            q_reg <= num_i[DW-1] ? DW'(-num_i) : num_i;
            neg_reg <= num_i[DW-1];
            den_reg <= den_i;
            acc_reg <= '0;
            cnt_reg <= CW'(DW);
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            acc_reg <= fits ? (shifted - {1'b0, den_reg}) : shifted;
            q_reg <= {q_reg[DW-2:0], fits};
            cnt_reg <= cnt_reg - CW'(1);
            if (cnt_reg == CW'(1)) begin
               busy_reg <= 1'b0;
               done_o <= 1'b1;
               quo_o <= neg_reg ? -$signed({q_reg[DW-2:0], fits}) : $signed({q_reg[DW-2:0], fits});
            end
         end
      end
   end
endmodule

// file: pid_regulator.sv
// process feedback combiner, lowpass filter and PID law with start-up handover
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pid_reg_consts.svh"

// Notes on behaviour
// R1 - minimum mode regulates on lower feedback
// R2 - maximum mode, the default, uses higher
// R3 - each feedback is bus value plus analog
// R4 - sum mode adds feedbacks, reference on setpoint1
// R5 - difference mode is feedback2 minus feedback1
// R6 - average mode takes mean, reference on setpoint1
// R7 - zone minimum picks larger signed setpoint gap
// R8 - zone minimum reference joins the chosen setpoint
// R9 - zone maximum picks smaller signed setpoint gap
// R10 - zone maximum reference joins the chosen setpoint
// R11 - single feedback modes use one input only
// R12 - setpoint2 acts only closed loop, zone modes; code also uses it in the feedback2 mode
// R13 - normal direction: rising feedback lowers output
// R14 - anti-windup tracks output, suspends until sign
// R15 - without anti-windup integrator keeps accumulating
// R16 - open-loop ramp to handover frequency first
// R17 - current limit before handover keeps regulator off
// R18 - proportional gain 0.00 to 10.00, default 0.01
// R19 - integral time 0.01..9999 s or off
// R20 - derivative follows error change, zero is off
// R21 - derivative gain clamped to ceiling 5..50
// R22 - first-order feedback lowpass, tau 0.01..10 s
// R23 - fixed sample period, saturating signed arithmetic
module pid_regulator #(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES_DEF
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire pid_reg_pkg::reg_req_s req_i,
   output logic [31:0] rd_data_o,
   input wire logic signed [15:0] fb1_pin_i,
   input wire logic signed [15:0] fb2_pin_i,
   input wire pid_reg_pkg::limit_s limit_pin_i,
   input wire logic [15:0] out_freq_i,
   output logic [15:0] freq_demand_o,
   output logic regulating_o
);
   import pid_reg_pkg::*;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) return 16'sh7FFF;
      if (v < -32'sd32768) return -16'sh8000;
      return v[15:0];
   endfunction

   function automatic logic signed [31:0] sat32(input logic signed [33:0] v);
      if (v > 34'sh07FFFFFFF) return 32'sh7FFFFFFF;
      if (v < -34'sh080000000) return -32'sh80000000;
      return v[31:0];
   endfunction

   function automatic logic [31:0] clampu(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   ctrl_s ctrl_reg;
   logic signed [15:0] sp1_reg, sp2_reg, rref_reg, bfb1_reg, bfb2_reg;
   logic [15:0] kp_reg, hfreq_reg, fmin_reg, fmax_reg;
   logic [19:0] ti_reg;
   logic [9:0] td_reg, tau_reg;
   logic [8:0] dgain_reg;

   // range limits applied on write so the datapath never sees illegal settings
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= `CTRL_RST;
         sp1_reg <= '0;
         sp2_reg <= '0;
         rref_reg <= '0;
         bfb1_reg <= '0;
         bfb2_reg <= '0;
         kp_reg <= `KP_RST;
         ti_reg <= '0;
         td_reg <= '0;
         dgain_reg <= 9'(`DG_MIN);
         tau_reg <= 10'(`TAU_MIN);
         hfreq_reg <= '0;
         fmin_reg <= '0;
         fmax_reg <= `FMAX_RST;
      end else if (req_i.wr) begin
         unique case (req_i.addr)
            `RG_CTRL: ctrl_reg <= req_i.wdata[7:0];
            `RG_SP1: sp1_reg <= req_i.wdata[15:0];
            `RG_SP2: sp2_reg <= req_i.wdata[15:0];
            `RG_RREF: rref_reg <= req_i.wdata[15:0];
            `RG_BFB1: bfb1_reg <= req_i.wdata[15:0];
            `RG_BFB2: bfb2_reg <= req_i.wdata[15:0];
            `RG_KP: kp_reg <= 16'(clampu(req_i.wdata, '0, `KP_MAX)); // R18
            `RG_TI: ti_reg <= 20'(clampu(req_i.wdata, '0, `TI_MAX)); // R19
            `RG_TD: td_reg <= 10'(clampu(req_i.wdata, '0, `TD_MAX)); // R20
            `RG_DGAIN: dgain_reg <= 9'(clampu(req_i.wdata, `DG_MIN, `DG_MAX)); // R21
            `RG_TAU: tau_reg <= 10'(clampu(req_i.wdata, `TAU_MIN, `TAU_MAX)); // R22
            `RG_HFREQ: hfreq_reg <= req_i.wdata[15:0];
            `RG_FMIN: fmin_reg <= req_i.wdata[15:0];
            `RG_FMAX: fmax_reg <= req_i.wdata[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   localparam int PW = 34;
   logic [PW-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_q_reg;
   logic signed [15:0] an1, an2;
   limit_s lim_q;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pin_q_reg <= '0;
      end else begin
         pin_s1_reg <= {fb1_pin_i, fb2_pin_i, limit_pin_i};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         if (pin_s2_reg == pin_s3_reg) pin_q_reg <= pin_s3_reg;
      end
   end
   assign {an1, an2, lim_q} = pin_q_reg;

   // ----------------------------------------------------------------
   // feedback combination
   // ----------------------------------------------------------------
   logic signed [15:0] fb1, fb2, d1, d2, fb_c, sp_c, ref_c;
   logic zsel2;

   assign fb1 = sat16(32'(bfb1_reg) + 32'(an1)); // R3
   assign fb2 = sat16(32'(bfb2_reg) + 32'(an2)); // R3
   assign d1 = sat16(32'(sp1_reg) - 32'(fb1));
   assign d2 = sat16(32'(sp2_reg) - 32'(fb2));

   // the second setpoint is only reached by the zone and second-input selections
   always_comb begin
      zsel2 = 1'b0;
      fb_c = fb1;
      sp_c = sp1_reg; // R4 R6
      unique case (ctrl_reg.feedback_combine_select)
         CMB_MIN: fb_c = (fb1 < fb2) ? fb1 : fb2; // R1
         CMB_MAX: fb_c = (fb1 > fb2) ? fb1 : fb2; // R2
         CMB_SUM: fb_c = sat16(32'(fb1) + 32'(fb2)); // R4
         CMB_DIFF: fb_c = sat16(32'(fb2) - 32'(fb1)); // R5
         CMB_AVG: fb_c = 16'((32'(fb1) + 32'(fb2)) >>> 1); // R6
         CMB_ZONE_MIN: zsel2 = d2 > d1; // R7
         CMB_ZONE_MAX: zsel2 = d2 < d1; // R9
         CMB_FB1: fb_c = fb1; // R11
         CMB_FB2: begin
            fb_c = fb2; // R11
            sp_c = sp2_reg;
         end
         default: fb_c = (fb1 > fb2) ? fb1 : fb2;
      endcase
      if (zsel2) begin
         fb_c = fb2;
         sp_c = sp2_reg; // R8 R10 R12
      end
   end
   assign ref_c = sat16(32'(sp_c) + 32'(rref_reg)); // R8 R10

   // ----------------------------------------------------------------
   // sample tick; time settings in hundredths of a second equal samples
   // ----------------------------------------------------------------
   logic [31:0] tick_cnt_reg;
   logic tick_reg;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         // wrap on the count itself so the period is exactly SAMPLE_CYCLES
         tick_reg <= tick_cnt_reg == 32'(SAMPLE_CYCLES - 1); // R23
         tick_cnt_reg <= (tick_cnt_reg == 32'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt_reg + 32'd1;
      end
   end

   // ----------------------------------------------------------------
   // start-up handover
   // ----------------------------------------------------------------
   run_phase_e phase_reg;
   logic run_req;
   assign run_req = ctrl_reg.start && ctrl_reg.closed_loop;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         phase_reg <= PH_STOP;
      end else begin
         unique case (phase_reg)
            PH_STOP: if (run_req) phase_reg <= PH_RAMP; // R16
            PH_RAMP: begin
               if (!run_req) phase_reg <= PH_STOP;
               else if (out_freq_i >= hfreq_reg && !lim_q.cur_lim) phase_reg <= PH_REG; // R16 R17
            end
            PH_REG: if (!run_req) phase_reg <= PH_STOP;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sampled calculation: filter, error, integral step, derivative
   // ----------------------------------------------------------------
   calc_state_e state_reg;
   logic div_go_reg, div_done;
   logic signed [31:0] div_num_reg, div_quo;
   logic [19:0] div_den_reg;
   logic signed [15:0] fbf_reg, ref_hold_reg, e_reg, err_c;
   logic signed [31:0] p_reg, p_c, dp_reg, iq_reg, d_reg;
   logic signed [47:0] p_full;
   logic [19:0] mult10;

   assign err_c = ctrl_reg.loop_direction_select ?
                  sat16(32'(fbf_reg) - 32'(ref_hold_reg)) :
                  sat16(32'(ref_hold_reg) - 32'(fbf_reg)); // R13
   assign p_full = $signed({1'b0, kp_reg}) * err_c;
   assign p_c = 32'(p_full >>> `KP_FRAC); // R18
   // derivative multiplier: time in samples, capped by the ceiling (tenths)
   assign mult10 = (20'(td_reg) * `DER_SCALE < 20'(dgain_reg)) ?
                   20'(td_reg) * `DER_SCALE : 20'(dgain_reg); // R21

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_WAIT;
         div_go_reg <= 1'b0;
         div_num_reg <= '0;
         div_den_reg <= '0;
         fbf_reg <= '0;
         ref_hold_reg <= '0;
         e_reg <= '0;
         p_reg <= '0;
         dp_reg <= '0;
         iq_reg <= '0;
         d_reg <= '0;
      end else begin
         div_go_reg <= 1'b0;
         unique case (state_reg)
            ST_WAIT: if (tick_reg) begin
               div_num_reg <= 32'(fb_c) - 32'(fbf_reg); // R22
               div_den_reg <= 20'(tau_reg);
               div_go_reg <= 1'b1;
               ref_hold_reg <= ref_c;
               state_reg <= ST_FILT; // R23
            end
            ST_FILT: if (div_done) begin
               fbf_reg <= sat16(div_quo + 32'(fbf_reg)); // R22 R23
               state_reg <= ST_ERR;
            end
            ST_ERR: begin
               e_reg <= err_c;
               p_reg <= p_c;
               dp_reg <= sat32(34'(p_c) - 34'(p_reg)); // R20
               div_num_reg <= p_c;
               div_den_reg <= (ti_reg == '0) ? 20'd1 : ti_reg; // R19
               div_go_reg <= 1'b1;
               state_reg <= ST_INT;
            end
            ST_INT: if (div_done) begin
               iq_reg <= (ti_reg == '0) ? '0 : div_quo; // R19
               div_num_reg <= 32'(dp_reg * $signed({1'b0, mult10})); // R20 R21
               div_den_reg <= `DER_SCALE;
               div_go_reg <= 1'b1;
               state_reg <= ST_DER;
            end
            ST_DER: if (div_done) begin
               d_reg <= div_quo;
               state_reg <= ST_OUT;
            end
            ST_OUT: state_reg <= ST_WAIT;
         endcase
      end
   end

   pid_divider #(.DW(32), .VW(20)) u_div (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .start_i(div_go_reg),
      .num_i(div_num_reg),
      .den_i(div_den_reg),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   // ----------------------------------------------------------------
   // integrator, anti-windup and frequency demand
   // ----------------------------------------------------------------
   logic signed [31:0] integ_reg;
   logic susp_reg, e_sign_reg, limited_c;
   logic signed [33:0] u_raw;
   logic [15:0] u_clamp;

   assign u_raw = 34'(integ_reg) + 34'(p_reg) + 34'(d_reg);
   assign u_clamp = (u_raw < 34'($signed({1'b0, fmin_reg}))) ? fmin_reg :
                    ((u_raw > 34'($signed({1'b0, fmax_reg}))) ? fmax_reg : u_raw[15:0]);
   assign limited_c = lim_q.cur_lim || lim_q.volt_lim ||
                      u_raw != 34'($signed({1'b0, u_clamp})); // R14
   // while suspended the demand follows the stage so no bump on release
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         integ_reg <= '0;
         susp_reg <= 1'b0;
         e_sign_reg <= 1'b0;
         freq_demand_o <= '0;
         regulating_o <= 1'b0;
      end else begin
         regulating_o <= phase_reg == PH_REG && !susp_reg;
         if (phase_reg != PH_REG) begin
            integ_reg <= 32'(out_freq_i); // R16
            susp_reg <= 1'b0;
            freq_demand_o <= (phase_reg == PH_RAMP) ? hfreq_reg : '0; // R16 R17
         end else if (state_reg == ST_OUT) begin
            if (ctrl_reg.integrator_clamp_enable && susp_reg) begin
               integ_reg <= 32'(out_freq_i); // R14
               freq_demand_o <= out_freq_i;
               if (e_reg == '0 || e_reg[15] != e_sign_reg) susp_reg <= 1'b0; // R14
            end else if (ctrl_reg.integrator_clamp_enable && limited_c) begin
               integ_reg <= 32'(out_freq_i); // R14
               susp_reg <= 1'b1;
               e_sign_reg <= e_reg[15];
               freq_demand_o <= out_freq_i;
            end else begin
               integ_reg <= sat32(34'(integ_reg) + 34'(iq_reg)); // R15 R23
               susp_reg <= 1'b0;
               freq_demand_o <= u_clamp;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= '0;
         if (req_i.rd) begin
            unique case (req_i.addr)
               `RG_CTRL: rd_data_o <= 32'(ctrl_reg);
               `RG_SP1: rd_data_o <= 32'(unsigned'(sp1_reg));
               `RG_SP2: rd_data_o <= 32'(unsigned'(sp2_reg));
               `RG_RREF: rd_data_o <= 32'(unsigned'(rref_reg));
               `RG_BFB1: rd_data_o <= 32'(unsigned'(bfb1_reg));
               `RG_BFB2: rd_data_o <= 32'(unsigned'(bfb2_reg));
               `RG_KP: rd_data_o <= 32'(kp_reg);
               `RG_TI: rd_data_o <= 32'(ti_reg);
               `RG_TD: rd_data_o <= 32'(td_reg);
               `RG_DGAIN: rd_data_o <= 32'(dgain_reg);
               `RG_TAU: rd_data_o <= 32'(tau_reg);
               `RG_HFREQ: rd_data_o <= 32'(hfreq_reg);
               `RG_FMIN: rd_data_o <= 32'(fmin_reg);
               `RG_FMAX: rd_data_o <= 32'(fmax_reg);
               `RG_STATUS: rd_data_o <= 32'({susp_reg, phase_reg, state_reg});
               `RG_FBF: rd_data_o <= 32'(unsigned'(fbf_reg));
               `RG_DEMAND: rd_data_o <= 32'(freq_demand_o);
               default: rd_data_o <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_ramp_ready;
      phase_reg == PH_RAMP && run_req && out_freq_i >= hfreq_reg && !lim_q.cur_lim;
   endsequence
   sequence s_clamp_hit;
      state_reg == ST_OUT && phase_reg == PH_REG && ctrl_reg.integrator_clamp_enable &&
      !susp_reg && limited_c;
   endsequence

   a_min_select: assert property ( // R1
      ctrl_reg.feedback_combine_select == CMB_MIN |-> fb_c <= fb1 && fb_c <= fb2)
      else $error("minimum mode did not pick lower feedback");
   a_max_select: assert property ( // R2
      ctrl_reg.feedback_combine_select == CMB_MAX |-> fb_c >= fb1 && fb_c >= fb2)
      else $error("maximum mode did not pick higher feedback");
   a_zone_min_pick: assert property ( // R7
      ctrl_reg.feedback_combine_select == CMB_ZONE_MIN |-> (zsel2 ? d2 > d1 : d1 >= d2))
      else $error("zone minimum chose the wrong zone");
   a_zone_max_pick: assert property ( // R9
      ctrl_reg.feedback_combine_select == CMB_ZONE_MAX |-> (zsel2 ? d2 < d1 : d1 <= d2))
      else $error("zone maximum chose the wrong zone");
   a_handover_step: assert property (s_ramp_ready |=> phase_reg == PH_REG) // R16
      else $error("handover to regulation missed");
   a_limit_blocks: assert property ( // R17
      phase_reg == PH_RAMP && lim_q.cur_lim |=> phase_reg != PH_REG)
      else $error("regulator engaged at current limit");
   a_clamp_track: assert property ( // R14
      s_clamp_hit |=> susp_reg && integ_reg == 32'($past(out_freq_i)) ##1 !regulating_o)
      else $error("anti-windup did not track output");
   a_stop_demand: assert property (phase_reg == PH_STOP |=> freq_demand_o == '0) // R16
      else $error("demand not zero when stopped");
   a_sample_start: assert property ( // R23
      state_reg == ST_WAIT && tick_reg |=> state_reg == ST_FILT ##[1:40] state_reg == ST_ERR)
      else $error("sample calculation did not start");
endmodule

// file: motor_stage_model.sv
// behavioural motor output stage that follows the frequency demand
`timescale 1ns/1ps
module motor_stage_model
   import pid_reg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [15:0] freq_demand_i,
   input wire logic hold_i,
   output logic [15:0] out_freq_o,
   output pid_reg_pkg::limit_s limit_o
);
   // --------------------------------------------------------------
   // output frequency ramp, held from rising while at current limit
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         out_freq_o <= 16'h0000;
      end else if (!hold_i && out_freq_o < freq_demand_i) begin
         out_freq_o <= out_freq_o + 16'h0001;
      end else if (out_freq_o > freq_demand_i) begin
         out_freq_o <= out_freq_o - 16'h0001;
      end
   end
   // volt limit never reached in this model
   assign limit_o = '{cur_lim: hold_i, volt_lim: 1'b0};
endmodule

// file: process_pid_feedback_regulator_tb.sv
// self-checking bench for the process regulator
`timescale 1ns/1ps
module process_pid_feedback_regulator_tb;
   import pid_reg_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   reg_req_s req = '0;
   logic [31:0] rd_data;
   logic signed [15:0] fb1_pin = 16'sh0000;
   logic signed [15:0] fb2_pin = 16'sh0000;
   logic hold = 1'b1;
   limit_s lim;
   logic [15:0] out_freq, demand;
   logic regulating;
   int num_errors = 0;
   int tests_run = 0;
   int b1, b2, p1, p2, s1, s2;
   int codes[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 8};
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   pid_regulator #(.SAMPLE_CYCLES(200)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .req_i(req), .rd_data_o(rd_data), .fb1_pin_i(fb1_pin), .fb2_pin_i(fb2_pin),
      .limit_pin_i(lim), .out_freq_i(out_freq), .freq_demand_o(demand),
      .regulating_o(regulating));
   motor_stage_model stage (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .freq_demand_i(demand),
      .hold_i(hold), .out_freq_o(out_freq), .limit_o(lim));
   // ---------------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      req.wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      req.rd <= 1'b0;
      #1 chk(rd_data, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_reg(input logic v);
      int n;
      for (n = 0; n < 800 && regulating !== v; n++) @(posedge clk_sys_i);
      chk({31'h0, regulating}, {31'h0, v});
   endtask
   // combined feedback expected from the selected function
   function automatic logic [15:0] exp_fb(input int c, input int f1, input int f2, input int s1,
                                          input int s2);
      int r;
      case (c)
         0: r = (f1 < f2) ? f1 : f2;
         1: r = (f1 > f2) ? f1 : f2;
         2: r = f1 + f2;
         3: r = f2 - f1;
         4: r = (f1 + f2) >>> 1;
         5: r = (s2 - f2 > s1 - f1) ? f2 : f1;
         6: r = (s2 - f2 < s1 - f1) ? f2 : f1;
         7: r = f1;
         default: r = f2;
      endcase
      return 16'(r);
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'haa6ff228));
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd_chk(8'h00, 32'h21);
      rd_chk(8'h18, 32'h29);
      rd_chk(8'h24, 32'h32);
      rd_chk(8'h28, 32'h01);
      rd_chk(8'h7C, 32'h00);
      wr(8'h18, 32'hFFFF);
      rd_chk(8'h18, 32'hA000);
      wr(8'h24, 32'h1);
      rd_chk(8'h24, 32'h32);
      wr(8'h28, 32'h0);
      rd_chk(8'h28, 32'h01);
      wr(8'h20, 32'hFFFF);
      rd_chk(8'h20, 32'h3E8);
      wr(8'h40, 32'h55);
      rd_chk(8'h40, 32'h0);
      foreach (codes[i]) begin
         b1 = $urandom_range(400);
         b2 = $urandom_range(400);
         p1 = $urandom_range(400);
         p2 = $urandom_range(400);
         s1 = $urandom_range(800);
         s2 = $urandom_range(800);
         if (i == 0) p2 = p1;
         // equal zone gaps: zone one must win
         if (i == 5) s2 = s1 - b1 - p1 + b2 + p2;
         wr(8'h00, 32'h20 | codes[i]);
         wr(8'h10, b1);
         wr(8'h14, b2);
         wr(8'h04, s1);
         wr(8'h08, s2);
         @(posedge clk_sys_i);
         fb1_pin <= 16'(p1);
         fb2_pin <= 16'(p2);
         repeat (450) @(posedge clk_sys_i);
         rd_chk(8'h3C, {16'h0, exp_fb(codes[i], b1 + p1, b2 + p2, s1, s2)});
      end
      // start-up handover held off by the current limit; unit gain, no I or D
      wr(8'h18, 32'h1000);
      wr(8'h20, 32'h0);
      wr(8'h04, b1 + p1 + 50);
      wr(8'h2C, 32'd100);
      wr(8'h00, 32'hC7);
      repeat (30) @(posedge clk_sys_i);
      chk({31'h0, regulating}, 32'h0);
      chk({16'h0, demand}, 32'd100);
      hold <= 1'b0;
      wait_reg(1'b1);
      chk({16'h0, out_freq >= 16'd100}, 32'h1);
      // integrator holds the handover frequency, error is plus or minus 50
      repeat (500) @(posedge clk_sys_i);
      chk({16'h0, demand}, 32'd150);
      wr(8'h00, 32'hD7);
      repeat (500) @(posedge clk_sys_i);
      chk({16'h0, demand}, 32'd50);
      // raising the floor above the demand must trip anti-windup
      wr(8'h00, 32'hF7);
      wr(8'h30, 32'd60);
      wait_reg(1'b0);
      chk({16'h0, demand}, 32'd50);
      wr(8'h00, 32'h21);
      wait_reg(1'b0);
      repeat (3) @(posedge clk_sys_i);
      chk({16'h0, demand}, 32'h0);
      stop_test();
   end
   initial begin
      #200us;
      num_errors++;
      $display("FAIL %0t run did not finish", $time);
      stop_test();
   end
endmodule
